// [aulu_consts.svh]
// Purpose: Constants of the address update and looping unit.
// Assumes: One clock; registers are 16 bits wide.
// Notes:   Mode word field positions and reset values.
`ifndef AULU_CONSTS_SVH
`define AULU_CONSTS_SVH

`define AULU_WIDTH        16
`define AULU_MODE_WIDTH   11
`define AULU_NUM_ADDR     16
`define AULU_NUM_OFFSET   6
`define AULU_NUM_PAIR     4
`define AULU_OFFSET_BANK  3

`define AULU_MASK_LSB     0
`define AULU_MASK_MSB     3
`define AULU_BIT_TRANSP   6
`define AULU_BIT_ABANK    7
`define AULU_BIT_OBANK    8
`define AULU_BIT_POST     9
`define AULU_BIT_ALT      10

`define AULU_MODE_RESET   11'h000
`define AULU_WORD_RESET   16'h0000
`define AULU_DATA_OFFSET  2'h3

`endif

// [aulu_pkg.sv]
// Purpose: Types of the address update and looping unit.
// Assumes: Constants come from aulu_consts.svh.
// Notes:   Instruction and register load words travel as structs.
`include "aulu_consts.svh"
`default_nettype none

package aulu_pkg;

    typedef enum logic [2:0] {
        OP_NONE                        = 3'h0,
        OP_OUTPUT_INCREMENT_LOOP       = 3'h1,
        OP_OUTPUT_DECREMENT_LOOP       = 3'h2,
        OP_OUTPUT_ADD_OFFSET_LOOP      = 3'h3,
        OP_OUTPUT_SUBTRACT_OFFSET_LOOP = 3'h4
    } op_t;

    typedef struct packed {
        op_t        op;
        logic [3:0] addr_sel;
        logic [1:0] offset_sel;
        logic [1:0] pair_sel;
    } instr_t;

    typedef enum logic [1:0] {
        TGT_ADDR   = 2'h0,
        TGT_OFFSET = 2'h1,
        TGT_COMP   = 2'h2,
        TGT_INIT   = 2'h3
    } target_t;

    typedef struct packed {
        logic                     valid;
        target_t                  target;
        logic [3:0]               index;
        logic [`AULU_WIDTH-1:0]   data;
    } reg_load_t;

endpackage : aulu_pkg

`default_nettype wire

// [address_update_looping_unit.sv]
// Purpose: Address generator that outputs an address register and
//          updates it by increment, decrement or offset, with a
//          boundary compare, re-initialization and alternate execution.
// Assumes: One clock of 125 MHz stands for one two-phase cycle; the
//          sequencer drives the instruction and data ports on this clock.
// Notes:   Only looping instructions drive the address port. The held
//          instruction cannot start a second fetch from the holder. A
//          mode write that clears alternate mode cancels a pending fetch
//          together with its pulse. Offset codes 3 and 7 have no storage:
//          they name the data port, so loads to them are dropped.
//          Transparent mode shows the port's value after the next clock edge and writes no
//          register. All boundary compares are unsigned. Precision bits
//          of the mode word are stored but have no effect.
//
// Function
// - Latched mode: address captured in a cycle and held at the port.
// - Latched address stays stable even if instruction inputs change.
// - Post-update mode outputs the updated value, even when the init value is written back.
// - Post-update lets data port values be modified and output in one cycle.
// - Pre-update outputs value before update; modified data needs two cycles.
// - Alternate mode: valid compare makes next instruction the held one.
// - Alternate mode suppresses re-initialization; default update always done.
// - Without alternate mode, re-initialization gated by the four mask bits.
// - Compare low does nothing; high raises flag pin, reloads if masked in.
// - Offset bank bit and two-bit code pick offset; code 11 is data port.
// - Data port offset code needs no external data select.
// - External data select replaces address register for output and update.
// - Bank bits supply top select bits; programmer picks bank first.
// - Address port driven only on output instructions, else released.
// - Loop instruction outputs, overwrites register, shows compare on pin.
// - Increment loop: compare greater-or-equal, reload or store plus one.
// - Decrement loop: subtract one, compare less-or-equal.
// - Add loop: add offset, compare greater-or-equal, sum output post-update.
// - Subtract loop: subtract offset, compare less-or-equal.
// - Transparent mode: address port shows idle inputs after the next clock edge.
`include "aulu_consts.svh"
`default_nettype none

module address_update_looping_unit (
    input  wire logic                         clock_i,
    input  wire logic                         nrst_i,
    input  wire aulu_pkg::instr_t             instr_i,
    input  wire logic                         instr_valid_i,
    input  wire logic [`AULU_WIDTH-1:0]       data_i,
    input  wire logic                         external_data_select_i,
    input  wire logic                         mode_load_i,
    input  wire logic [`AULU_MODE_WIDTH-1:0]  mode_word_i,
    input  wire logic                         alt_load_i,
    input  wire aulu_pkg::instr_t             alt_word_i,
    input  wire aulu_pkg::reg_load_t          reg_load_i,
    output logic [`AULU_WIDTH-1:0]            addr_o,
    output logic                              addr_oe_o,
    output logic                              compare_zero_flag_pin_o,
    output logic                              alt_taken_o,
    output logic [`AULU_MODE_WIDTH-1:0]       mode_control_word_o
);
    import aulu_pkg::*;

    typedef logic [`AULU_WIDTH-1:0] word_t;

    typedef struct packed {
        logic [`AULU_MODE_WIDTH-1:0]         mode;
        logic [`AULU_NUM_ADDR-1:0][15:0]     addr_reg;
        logic [`AULU_NUM_OFFSET-1:0][15:0]   offset_reg;
        logic [`AULU_NUM_PAIR-1:0][15:0]     comp_reg;
        logic [`AULU_NUM_PAIR-1:0][15:0]     init_reg;
        instr_t                              alt_instr;
        logic                                alt_pending;
        word_t                               addr;
        logic                                addr_oe;
        logic                                cmp;
        logic                                alt_taken;
    } state_t;

    state_t s;
    state_t next_s;

    // Decoded view of the instruction that is executed this cycle.
    instr_t     cur;
    logic       active;
    logic       is_loop;
    logic       is_offset_op;
    logic       is_down;
    logic [3:0] r_idx;
    logic [2:0] b_idx;
    word_t      r_val;
    word_t      offset;
    word_t      step;
    word_t      updated;
    word_t      compared;
    word_t      c_val;
    word_t      i_val;
    word_t      shown;
    logic       cmp_true;
    logic       reinit;
    logic       post_mode;
    logic       alt_mode;
    logic       transp_mode;
    logic       offset_from_port;
    // Write-back, alternate fetch and register load decode.
    logic       mask_hit;
    logic       take_alt;
    logic       cancel_alt;
    logic       at_or_above;
    logic       at_or_below;
    word_t      store_val;
    logic       wr_addr;
    logic       wr_offset;
    logic       wr_comp;
    logic       wr_init;
    logic [2:0] wr_offset_idx;
    logic [1:0] wr_pair_idx;

    assign post_mode   = s.mode[`AULU_BIT_POST];
    assign alt_mode    = s.mode[`AULU_BIT_ALT];
    assign transp_mode = s.mode[`AULU_BIT_TRANSP];

    // A mode write that turns alternate mode off wins over a pending
    // fetch from the holder, and the pulse that announced it goes too.
    assign cancel_alt = mode_load_i && !mode_word_i[`AULU_BIT_ALT];

    // The held instruction takes the place of the port for one cycle.
    always_comb begin
        if (s.alt_pending) begin
            cur    = s.alt_instr;
            active = 1'b1;
        end else begin
            cur    = instr_i;
            active = instr_valid_i;
        end
    end

    always_comb begin
        is_loop      = (cur.op != OP_NONE);
        is_offset_op = (cur.op == OP_OUTPUT_ADD_OFFSET_LOOP) ||
                       (cur.op == OP_OUTPUT_SUBTRACT_OFFSET_LOOP);
        is_down      = (cur.op == OP_OUTPUT_DECREMENT_LOOP) ||
                       (cur.op == OP_OUTPUT_SUBTRACT_OFFSET_LOOP);
    end

    // Offset and add/subtract address selects take their top bit from
    // the mode word.
    always_comb begin
        if (is_offset_op) begin
            r_idx = {s.mode[`AULU_BIT_ABANK], cur.addr_sel[2:0]};
        end else begin
            r_idx = cur.addr_sel;
        end
        if (s.mode[`AULU_BIT_OBANK]) begin
            b_idx = 3'(`AULU_OFFSET_BANK) + {1'b0, cur.offset_sel};
        end else begin
            b_idx = {1'b0, cur.offset_sel};
        end
    end

    // External data stands in for the address register.
    always_comb begin
        if (external_data_select_i && !s.alt_pending) begin
            r_val = data_i;
        end else begin
            r_val = s.addr_reg[r_idx];
        end
    end

    // Code 11 reads the data port in either bank without the select pin.
    always_comb begin
        offset_from_port = (cur.offset_sel == `AULU_DATA_OFFSET);
        if (offset_from_port) begin
            offset = data_i;
        end else begin
            offset = s.offset_reg[b_idx];
        end
    end

    always_comb begin
        if (is_offset_op) begin
            step = offset;
        end else begin
            step = 16'h0001;
        end
        if (is_down) begin
            updated = r_val - step;
        end else begin
            updated = r_val + step;
        end
    end

    // Pre-update compares and shows the old value, post-update the new.
    always_comb begin
        if (post_mode) begin
            compared = updated;
        end else begin
            compared = r_val;
        end
        shown = compared;
        c_val = s.comp_reg[cur.pair_sel];
        i_val = s.init_reg[cur.pair_sel];
    end

    // Both boundary tests are unsigned; the loop direction picks one.
    // The pair select also picks one of the four mask bits.
    always_comb begin
        at_or_above = (compared >= c_val);
        at_or_below = (compared <= c_val);
        mask_hit    = s.mode[`AULU_MASK_LSB + 32'(cur.pair_sel)];
    end

    always_comb begin
        if (is_down) begin
            cmp_true = at_or_below;
        end else begin
            cmp_true = at_or_above;
        end
        reinit = is_loop && cmp_true && !alt_mode && mask_hit;
    end

    // The paired init value replaces the default update only when the
    // mask allows it and alternate mode is off.
    always_comb begin
        if (reinit) begin
            store_val = i_val;
        end else begin
            store_val = updated;
        end
        take_alt = cmp_true && alt_mode && !s.alt_pending;
    end

    // Register loads come in on the load port; only one target is
    // written per cycle, and offset index 4 to 6 lands in storage 3 to 5
    // because the data port code owns the fourth slot of each bank.
    always_comb begin
        wr_addr     = 1'b0;
        wr_offset   = 1'b0;
        wr_comp     = 1'b0;
        wr_init     = 1'b0;
        wr_pair_idx = reg_load_i.index[1:0];
        if (reg_load_i.index[2]) begin
            wr_offset_idx = 3'(`AULU_OFFSET_BANK) +
                            {1'b0, reg_load_i.index[1:0]};
        end else begin
            wr_offset_idx = {1'b0, reg_load_i.index[1:0]};
        end
        if (reg_load_i.valid) begin
            unique case (reg_load_i.target)
                TGT_ADDR: begin
                    wr_addr = 1'b1;
                end
                TGT_OFFSET: begin
                    wr_offset = (reg_load_i.index[1:0] != `AULU_DATA_OFFSET);
                end
                TGT_COMP: begin
                    wr_comp = 1'b1;
                end
                TGT_INIT: begin
                    wr_init = 1'b1;
                end
            endcase
        end
    end

    always_comb begin
        next_s           = s;
        next_s.alt_taken = 1'b0;

        if (mode_load_i) begin
            next_s.mode = mode_word_i;
        end

        if (alt_load_i) begin
            next_s.alt_instr = alt_word_i;
        end

        if (wr_addr) begin
            next_s.addr_reg[reg_load_i.index] = reg_load_i.data;
        end
        if (wr_offset) begin
            next_s.offset_reg[wr_offset_idx] = reg_load_i.data;
        end
        if (wr_comp) begin
            next_s.comp_reg[wr_pair_idx] = reg_load_i.data;
        end
        if (wr_init) begin
            next_s.init_reg[wr_pair_idx] = reg_load_i.data;
        end

        next_s.alt_pending = 1'b0;

        if (active && is_loop) begin
            // Output value captured now and held until the next one.
            next_s.addr    = shown;
            next_s.addr_oe = 1'b1;
            next_s.addr_reg[r_idx] = store_val;
            if (cmp_true) begin
                next_s.cmp = 1'b1;
            end else begin
                next_s.cmp = 1'b0;
            end
            if (take_alt) begin
                next_s.alt_pending = 1'b1;
                next_s.alt_taken   = 1'b1;
            end
        end else if (active) begin
            next_s.addr_oe = 1'b0;
        end else if (transp_mode) begin
            // Transparent port follows whatever the port offers; no
            // register is written, and the value may move with the port.
            next_s.addr_oe = is_loop;
            if (is_loop) begin
                next_s.addr = shown;
            end
        end else begin
            next_s.addr_oe = 1'b0;
        end

        if (cancel_alt) begin
            next_s.alt_pending = 1'b0;
            next_s.alt_taken   = 1'b0;
        end
    end

    // Reset clears the whole state, so the port comes up released and
    // every register reads zero until it is loaded.
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            s             <= '0;
            s.mode        <= `AULU_MODE_RESET;
            s.addr        <= `AULU_WORD_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign addr_o                  = s.addr;
    assign addr_oe_o               = s.addr_oe;
    assign compare_zero_flag_pin_o = s.cmp;
    assign alt_taken_o             = s.alt_taken;
    assign mode_control_word_o     = s.mode;

endmodule : address_update_looping_unit

`default_nettype wire

// [aulu_assertions.sv]
// Purpose: Port checker for the address update and looping unit.
// Assumes: One clock; synchronous active-low reset.
// Notes:   Bound to the unit after the module.
`include "aulu_consts.svh"
`default_nettype none
module aulu_checker (
    input wire logic                        clock_i,
    input wire logic                        nrst_i,
    input wire aulu_pkg::instr_t            instr_i,
    input wire logic                        instr_valid_i,
    input wire logic [`AULU_WIDTH-1:0]      data_i,
    input wire logic                        external_data_select_i,
    input wire logic                        mode_load_i,
    input wire logic [`AULU_MODE_WIDTH-1:0] mode_word_i,
    input wire logic                        alt_load_i,
    input wire aulu_pkg::instr_t            alt_word_i,
    input wire aulu_pkg::reg_load_t         reg_load_i,
    input wire logic [`AULU_WIDTH-1:0]      addr_o,
    input wire logic                        addr_oe_o,
    input wire logic                        compare_zero_flag_pin_o,
    input wire logic                        alt_taken_o,
    input wire logic [`AULU_MODE_WIDTH-1:0] mode_control_word_o
);
    import aulu_pkg::*;
    logic [`AULU_MODE_WIDTH-1:0] m;
    logic                        go;
    logic                        dx;
    assign m = mode_control_word_o;
    assign go = instr_valid_i && !alt_taken_o && instr_i.op != OP_NONE;
    assign dx = go && external_data_select_i;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    a_reset_clear: assert property (
        $rose(nrst_i) |-> !addr_oe_o && !alt_taken_o && m == '0)
        else $error("state not clear after reset");
    a_loop_drive: assert property (go |=> addr_oe_o)
        else $error("loop instruction left port released");
    a_latch_hold: assert property (
        !instr_valid_i && !alt_taken_o && !mode_load_i
        && !m[`AULU_BIT_TRANSP] |=> !addr_oe_o && $stable(addr_o))
        else $error("latched port moved while idle");
    a_post_data: assert property (
        dx && m[`AULU_BIT_POST] && instr_i.op == OP_OUTPUT_INCREMENT_LOOP
        |=> addr_o == $past(data_i) + 16'h0001)
        else $error("post-update data not output in one cycle");
    a_pre_data: assert property (
        dx && !m[`AULU_BIT_POST] |=> addr_o == $past(data_i))
        else $error("pre-update data not output unmodified");
    a_alt_cause: assert property (
        alt_taken_o |-> compare_zero_flag_pin_o && m[`AULU_BIT_ALT])
        else $error("held instruction taken without cause");
    a_alt_single: assert property (alt_taken_o |=> !alt_taken_o)
        else $error("held instruction fetch chained");
    a_alt_off: assert property (
        !m[`AULU_BIT_ALT] && !mode_load_i |=> !alt_taken_o)
        else $error("held instruction taken with mode off");
    a_transp_follow: assert property (
        !instr_valid_i && !alt_taken_o && !mode_load_i
        && m[`AULU_BIT_TRANSP] && instr_i.op != OP_NONE |=> addr_oe_o)
        else $error("transparent port not driven");
    c_alt: cover property (alt_taken_o);
    c_transp: cover property (!instr_valid_i && m[`AULU_BIT_TRANSP]
        && instr_i.op != OP_NONE);
    c_flag: cover property ($rose(compare_zero_flag_pin_o));
    c_post: cover property (dx && m[`AULU_BIT_POST]);
endmodule : aulu_checker
bind address_update_looping_unit aulu_checker chk_u (
    .clock_i(clock_i), .nrst_i(nrst_i), .instr_i(instr_i),
    .instr_valid_i(instr_valid_i), .data_i(data_i),
    .external_data_select_i(external_data_select_i),
    .mode_load_i(mode_load_i), .mode_word_i(mode_word_i),
    .alt_load_i(alt_load_i), .alt_word_i(alt_word_i),
    .reg_load_i(reg_load_i), .addr_o(addr_o), .addr_oe_o(addr_oe_o),
    .compare_zero_flag_pin_o(compare_zero_flag_pin_o),
    .alt_taken_o(alt_taken_o), .mode_control_word_o(mode_control_word_o));
`default_nettype wire

// [aulu_seq_model.sv]
// Purpose: Sequencer model feeding instructions and external data.
// Assumes: The bench posts requests between clock edges.
// Notes:   A released data bus shows the inverse of its last value.
`include "aulu_consts.svh"
`default_nettype none
module aulu_seq_model (
    input  wire logic                   clock_i,
    input  wire logic                   req_valid_i,
    input  wire aulu_pkg::instr_t       req_instr_i,
    input  wire logic [`AULU_WIDTH-1:0] req_data_i,
    input  wire logic                   req_external_data_select_i,
    output var logic                    instr_valid_o,
    output var aulu_pkg::instr_t        instr_o,
    output var logic [`AULU_WIDTH-1:0]  data_o,
    output var logic                    external_data_select_o
);
    import aulu_pkg::*;
    initial begin
        {instr_valid_o, instr_o, data_o, external_data_select_o} = '0;
    end
    always @(negedge clock_i) begin
        instr_valid_o <= req_valid_i;
        instr_o       <= req_instr_i;
        external_data_select_o        <= req_valid_i && req_external_data_select_i;
        data_o        <= req_valid_i ? req_data_i : ~data_o;
    end
endmodule : aulu_seq_model
`default_nettype wire

// [tb.sv]
// Purpose: Self-checking bench for the address update and looping unit.
// Assumes: The sequencer model drives instructions on falling edges.
// Notes:   Random loop traffic with directed boundary and alternate cases.
`include "aulu_consts.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import aulu_pkg::*;
    typedef struct packed {
        logic [15:0] o;
        logic        c;
        logic [15:0] v;
        logic [3:0]  n;
    } exp_t;
    logic        clock_i, nrst_i, req_v, req_s, vld, external_data_select, mload, aload;
    logic        oe, flag, alt_t, pend, tr;
    exp_t        ei;
    logic [15:0] req_d, data, addr;
    logic [10:0] mword, mode_o, md;
    instr_t      req_i, instr, aword, aw, x, a;
    reg_load_t   rload;
    logic [15:0] r [16];
    logic [15:0] ofs [8];
    logic [15:0] c [4];
    logic [15:0] ini [4];
    int          errors, compares, k;
    always #4 clock_i = ~clock_i;
    aulu_seq_model seq_u (.clock_i(clock_i), .req_valid_i(req_v),
        .req_instr_i(req_i), .req_data_i(req_d), .req_external_data_select_i(req_s),
        .instr_valid_o(vld), .instr_o(instr), .data_o(data), .external_data_select_o(external_data_select));
    address_update_looping_unit dut_u (.clock_i(clock_i), .nrst_i(nrst_i),
        .instr_i(instr), .instr_valid_i(vld), .data_i(data),
        .external_data_select_i(external_data_select), .mode_load_i(mload),
        .mode_word_i(mword), .alt_load_i(aload), .alt_word_i(aword),
        .reg_load_i(rload), .addr_o(addr), .addr_oe_o(oe),
        .compare_zero_flag_pin_o(flag), .alt_taken_o(alt_t),
        .mode_control_word_o(mode_o));
    function automatic exp_t calc(instr_t y, logic [15:0] d, logic s);
        exp_t        e;
        logic [15:0] b, u;
        logic        up;
        up = y.op inside {OP_OUTPUT_INCREMENT_LOOP, OP_OUTPUT_ADD_OFFSET_LOOP};
        e.n = y.op inside {OP_OUTPUT_ADD_OFFSET_LOOP,
            OP_OUTPUT_SUBTRACT_OFFSET_LOOP} ? {md[7], y.addr_sel[2:0]}
            : y.addr_sel;
        b = y.offset_sel == 2'h3 ? d : ofs[{md[8], y.offset_sel}];
        u = s ? d : r[e.n];
        case (y.op)
            OP_OUTPUT_INCREMENT_LOOP: u = u + 16'h0001;
            OP_OUTPUT_DECREMENT_LOOP: u = u - 16'h0001;
            OP_OUTPUT_ADD_OFFSET_LOOP: u = u + b;
            default: u = u - b;
        endcase
        e.o = md[9] ? u : (s ? d : r[e.n]);
        e.c = up ? e.o >= c[y.pair_sel] : e.o <= c[y.pair_sel];
        e.v = e.c && md[y.pair_sel] && !md[10] ? ini[y.pair_sel] : u;
        return e;
    endfunction : calc
    task automatic check(logic [19:0] got, logic [19:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic issue(instr_t xi, logic [15:0] d, logic s);
        exp_t   e;
        instr_t y;
        logic   ap;
        {req_v, req_i, req_d, req_s} = {1'b1, xi, d, s};
        y = pend ? aw : xi;
        e = calc(y, d, s && !pend);
        ap = y.op != OP_NONE && e.c && md[10] && !pend;
        @(posedge clock_i) #1;
        if (y.op == OP_NONE) begin
            check({19'h0, oe}, 20'h0);
        end else begin
            check({1'b0, addr, oe, flag, alt_t},
                {1'b0, e.o, 1'b1, e.c, ap});
            r[e.n] = e.v;
        end
        pend = ap;
    endtask : issue
    task automatic ld(target_t t, logic [3:0] i, logic [15:0] v);
        req_v = 1'b0;
        @(negedge clock_i) rload <= {1'b1, t, i, v};
        @(negedge clock_i) rload <= '0;
        @(posedge clock_i) #1;
        case (t)
            TGT_ADDR: r[i] = v;
            TGT_OFFSET: ofs[i[2:0]] = v;
            TGT_COMP: c[i[1:0]] = v;
            default: ini[i[1:0]] = v;
        endcase
    endtask : ld
    task automatic ctl(logic [10:0] m, instr_t h);
        req_v = 1'b0;
        @(negedge clock_i) {mload, aload, mword, aword} <= {2'b11, m, h};
        @(negedge clock_i) {mload, aload} <= 2'b00;
        @(posedge clock_i) #1;
        md = m;
        aw = h;
        check({9'h0, mode_o}, {9'h0, m});
    endtask : ctl
    task automatic test_done();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done
    initial begin
        {clock_i, nrst_i, req_v, req_s, mload, aload, pend} = '0;
        {req_d, req_i, mword, aword, rload, md, aw} = '0;
        errors = 0;
        compares = 0;
        void'($urandom(17370));
        repeat (5) @(negedge clock_i);
        nrst_i <= 1'b1;
        @(posedge clock_i) #1;
        check({3'h0, mode_o, oe, flag, alt_t, 3'h0}, 20'h0);
        for (k = 0; k < 16; k++) begin
            ld(TGT_ADDR, 4'(k), 16'($urandom));
            if (k < 8 && k % 4 != 3) ld(TGT_OFFSET, 4'(k), 16'($urandom));
            if (k < 4) ld(TGT_COMP, 4'(k), 16'($urandom));
            if (k < 4) ld(TGT_INIT, 4'(k), 16'($urandom));
        end
        // Equal to the bound must count as reached for every loop kind.
        for (k = 1; k < 5; k++) begin
            ctl(11'h00f, aw);
            ld(TGT_ADDR, 4'h0, 16'h0010);
            ld(TGT_COMP, 4'h0, 16'h0010);
            issue({op_t'(k), 8'h00}, 16'h5a5a, 1'b0);
        end
        ctl(11'h40f, {OP_OUTPUT_DECREMENT_LOOP, 4'h5, 2'h1, 2'h2});
        ld(TGT_ADDR, 4'h0, 16'h0010);
        issue({OP_OUTPUT_INCREMENT_LOOP, 8'h00}, 16'h0000, 1'b0);
        issue({OP_NONE, 8'h00}, 16'hffff, 1'b1);
        for (k = 0; k < 400; k++) begin
            x = instr_t'($urandom);
            x.op = op_t'($urandom % 5);
            a = instr_t'($urandom);
            a.op = op_t'(1 + $urandom % 4);
            if (!pend && $urandom % 16 == 0) begin
                ctl(11'($urandom) & 11'h7cf, a);
            end else if (!pend && $urandom % 8 == 0) begin
                // Idle cycle with a changing instruction port.
                {req_v, req_i} = {1'b0, x};
                @(negedge clock_i) #1;
                tr = md[6] && instr.op != OP_NONE;
                ei = calc(instr, data, 1'b0);
                if (!tr) ei.o = addr;
                @(posedge clock_i) #1;
                check({3'h0, addr, oe}, {3'h0, ei.o, tr});
            end else begin
                issue(x, 16'($urandom), $urandom % 4 == 0);
            end
        end
        test_done();
    end
endmodule : tb
`default_nettype wire
